// File: bench/gds_master_model.sv
// serial master model that drives select, clock and data into the slave
`timescale 1ns/1ps
module gds_master_model (
   // serial pins
   output logic cs_n,
   output logic sclk,
   output logic si,
   input wire logic so
);
   // 400 ns link clock, unrelated to the system clock
   localparam int HALF = 200;

   // idle levels: select high, clock low
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      si = 1'b0;
   end

   // one frame of n bits, msb first; the received bits are gathered msb first
   task automatic xfer(input logic [63:0] tx, input int n, output logic [63:0] rx);
      rx = '0;
      sclk = 1'b0;
      cs_n = 1'b0;
      #HALF;
      for (int i = n - 1; i >= 0; i--) begin
         sclk = 1'b1;
         si = tx[i];
         #HALF;
         rx = {rx[62:0], so};
         sclk = 1'b0;
         #HALF;
      end
      si = ~si; // leave no stale data level behind the frame
      cs_n = 1'b1;
      // high time of sixteen system clocks covers sync, push and register write
      #(4 * HALF);
   endtask

   // clock and data activity with select high, which the slave must ignore
   task automatic noise(input logic [15:0] pat);
      for (int i = 15; i >= 0; i--) begin
         si = pat[i];
         sclk = 1'b1;
         #HALF;
         sclk = 1'b0;
         #HALF;
      end
   endtask
endmodule

// File: bench/test_gauge_driver_spi_slave.sv
// self-checking bench of the gauge driver serial slave
`timescale 1ns/1ps
`include "gds_cfg.svh"
module test_gauge_driver_spi_slave
   import gds_pkg::*;
;
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   logic cmd_accept = 1'b1;
   logic [15:0] status_word = 16'h0000;
   logic cs_n;
   logic sclk;
   logic si;
   logic so_out;
   logic so_oe;
   wire logic so_wire;
   logic frame_ready;
   logic [5:0] write_strobe;
   logic [12:0] got [6];
   logic [12:0] exp_reg [6] = '{default: 13'h0000};
   int exp_cnt [6] = '{default: 0};
   int str_cnt [6] = '{default: 0};
   logic [15:0] pend [$];
   int mismatches = 0;
   int checks_done = 0;
   int cycles = 0;

   // 20 MHz system clock
   always #25 clk_sys = ~clk_sys;

   // no pull on the output pin: an undriven pin reads as z and fails compares
   assign so_wire = so_oe ? so_out : 1'bz;

   gds_spi_slave i_dut (
      .clk_sys(clk_sys), .sys_rst(sys_rst), .cs_n(cs_n), .sclk(sclk), .si(si),
      .so_out(so_out), .so_oe(so_oe), .so_in(so_wire), .status_word(status_word),
      .cmd_accept(cmd_accept), .frame_ready(frame_ready), .write_strobe(write_strobe),
      .power_enable_calibration(got[0]), .maximum_velocity(got[1]),
      .gauge0_position(got[2]), .gauge1_position(got[3]),
      .return_to_zero(got[4]), .return_to_zero_config(got[5])
   );

   gds_master_model i_master (.cs_n(cs_n), .sclk(sclk), .si(si), .so(so_wire));

   // strobe pulses per register, tallied against the expected write count
   always @(posedge clk_sys) begin
      for (int i = 0; i < 6; i++) begin
         if (!sys_rst && write_strobe[i] === 1'b1) begin
            str_cnt[i]++;
         end
      end
   end

   // hang guard, well above the expected run of about six and a half thousand cycles
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 40000) begin
         mismatches++;
         finish_test();
      end
   end

   task automatic finish_test();
      if (mismatches == 0 && checks_done > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [63:0] got_v, input logic [63:0] exp_v, input string what);
      checks_done++;
      if (got_v !== exp_v) begin
         mismatches++;
         $display("MISMATCH %0t %s got %h exp %h", $time, what, got_v, exp_v);
      end
   endtask

   // codes 6 and 7 and the null power command leave every register alone
   function automatic bit writes(input logic [15:0] w);
      return (w[15:13] < 3'h6) && !(w[15:13] == 3'h0 && w[12]);
   endfunction

   task automatic apply_pending();
      logic [15:0] w;
      while (pend.size() > 0) begin
         w = pend.pop_front();
         if (writes(w)) begin
            exp_reg[w[15:13]] = w[12:0];
            exp_cnt[w[15:13]]++;
         end
      end
   endtask

   task automatic check_regs();
      for (int i = 0; i < 6; i++) begin
         chk(got[i], exp_reg[i], "register");
         chk(str_cnt[i], exp_cnt[i], "strobe count");
      end
   endtask

   // one frame; keep says whether the fifo has room for it
   task automatic send(input logic [63:0] tx, input int n, input bit keep);
      logic [63:0] rx;
      logic [63:0] mask;
      logic [15:0] st;
      @(posedge clk_sys);
      #3;
      st = 16'($urandom());
      status_word = st;
      i_master.xfer(tx, n, rx);
      if (n >= 16) begin
         chk(rx[n-1 -: 16], st, "status out");
      end
      if (n > 16) begin
         mask = (64'h1 << (n - 16)) - 64'h1;
         chk(rx & mask, (tx >> 16) & mask, "echo out");
      end
      chk(so_oe, 1'b0, "output enable idle");
      if (keep && n > 0 && n % 16 == 0) begin
         pend.push_back(tx[15:0]);
      end
      if (cmd_accept) begin
         apply_pending();
         check_regs();
      end
   endtask

   initial begin
      logic [15:0] w;
      void'($urandom(32'he6e0));
      repeat (16) @(posedge clk_sys);
      #3;
      sys_rst = 1'b0;
      check_regs();
      chk(so_oe, 1'b0, "enable after reset");
      chk(frame_ready, 1'b1, "room after reset");
      // every code, with bit 12 clear and set, the latter being null for code 0
      for (int c = 0; c < 8; c++) begin
         for (int r = 0; r < 2; r++) begin
            w = {3'(c), 1'(r), 12'($urandom())};
            send(w, 16, 1'b1);
         end
      end
      repeat (10) send(64'($urandom()) & 64'hffff, 16, 1'b1);
      // chained frame: the last word is ours, the first comes back out
      send({32'h0, 32'($urandom())}, 32, 1'b1);
      send({16'h0, 48'($urandom())}, 48, 1'b1);
      // frames not a whole number of words are dropped
      send(64'h0000_0000_0001_2345, 17, 1'b1);
      send(64'h0000_0000_0000_4a5a, 15, 1'b1);
      send(64'h0000_0000_0000_00a5, 8, 1'b1);
      send(64'h0, 0, 1'b1);
      // activity with select high changes nothing
      @(posedge clk_sys);
      #3;
      i_master.noise(16'h4fff);
      repeat (8) @(posedge clk_sys);
      chk(so_oe, 1'b0, "enable during noise");
      check_regs();
      // fill the fifo while the motor logic stalls, then drain it
      cmd_accept = 1'b0;
      for (int i = 0; i < 9; i++) begin
         send({48'h0, 3'h2, 13'($urandom())}, 16, i < 8);
      end
      chk(frame_ready, 1'b0, "fifo full");
      @(posedge clk_sys);
      #3;
      cmd_accept = 1'b1;
      repeat (12) @(posedge clk_sys);
      apply_pending();
      check_regs();
      chk(frame_ready, 1'b1, "fifo drained");
      finish_test();
   end
endmodule

// File: core/gds_fifo.sv
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module gds_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   logic push;
   logic pop;

   // honest flags straight from the fill count
   assign in_ready = (count != (AW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;
   assign out_data = mem[rd_ptr];

   // storage has no reset, only pointers and count need one
   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   // pointers wrap at the depth, which need not be a power of two
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + AW'(1);
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + AW'(1);
         end
      end
   end

   // fill count
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         count <= '0;
      end else if (push && !pop) begin
         count <= count + (AW+1)'(1);
      end else if (pop && !push) begin
         count <= count - (AW+1)'(1);
      end
   end
endmodule

// File: core/gds_spi_slave.sv
// serial command front end of a dual gauge stepper driver
`timescale 1ns/1ps
`include "gds_cfg.svh"
module gds_spi_slave
   import gds_pkg::*;
(
   // system clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // serial pins from the master
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic si,
   // serial output pin, three signals
   output logic so_out,
   output logic so_oe,
   input wire logic so_in,
   // status word from the motor logic
   input wire logic [`GDS_WORD_BITS-1:0] status_word,
   // command hand-off to the motor logic
   input wire logic cmd_accept,
   output logic frame_ready,
   output logic [`GDS_REG_COUNT-1:0] write_strobe,
   // functional registers
   output logic [`GDS_DATA_BITS-1:0] power_enable_calibration,
   output logic [`GDS_DATA_BITS-1:0] maximum_velocity,
   output logic [`GDS_DATA_BITS-1:0] gauge0_position,
   output logic [`GDS_DATA_BITS-1:0] gauge1_position,
   output logic [`GDS_DATA_BITS-1:0] return_to_zero,
   output logic [`GDS_DATA_BITS-1:0] return_to_zero_config
);

   // address field of a received word
   function automatic gds_addr_t word_addr(input logic [`GDS_WORD_BITS-1:0] w);
      word_addr = gds_addr_t'(w[`GDS_ADDR_MSB:`GDS_ADDR_LSB]);
   endfunction

   // true when the word is a null status read aimed at the power register
   function automatic logic is_null_cmd(input logic [`GDS_WORD_BITS-1:0] w);
      is_null_cmd = (word_addr(w) == GDS_REG_POWER) && w[`GDS_NULL_BIT];
   endfunction

   // synchronised pins
   logic cs_n_m;
   logic cs_n_s;
   logic cs_n_d;
   logic sclk_m;
   logic sclk_s;
   logic sclk_d;
   logic si_m;
   logic si_s;

   // link decode
   gds_link_state_t state;
   logic cs_fall;
   logic cs_rise;
   logic sclk_rise;
   logic sclk_fall;
   logic link_active;

   // shift machinery
   logic [`GDS_WORD_BITS-1:0] rx;
   logic [`GDS_WORD_BITS-1:0] tx;
   logic [3:0] bit_cnt;
   logic any_bit;
   logic frame_ok;

   // queue between the link and the register file
   logic push_valid;
   logic fifo_out_valid;
   logic [`GDS_WORD_BITS-1:0] fifo_out;
   logic pop;
   gds_addr_t pop_addr;

   // register file
   logic [`GDS_DATA_BITS-1:0] reg_file [`GDS_REG_COUNT];

   // two flops on every pin before any logic looks at it
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         cs_n_m <= 1'b1;
         cs_n_s <= 1'b1;
         sclk_m <= 1'b0;
         sclk_s <= 1'b0;
         si_m <= 1'b0;
         si_s <= 1'b0;
      end else begin
         cs_n_m <= cs_n;
         cs_n_s <= cs_n_m;
         sclk_m <= sclk;
         sclk_s <= sclk_m;
         si_m <= si;
         si_s <= si_m;
      end
   end

   // third stage, for edge finding only
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         cs_n_d <= 1'b1;
         sclk_d <= 1'b0;
      end else begin
         cs_n_d <= cs_n_s;
         sclk_d <= sclk_s;
      end
   end

   // edges; clock edges only count inside a frame
   assign cs_fall = !cs_n_s && cs_n_d;
   assign cs_rise = cs_n_s && !cs_n_d;
   assign link_active = (state != GDS_LINK_IDLE);
   assign sclk_rise = sclk_s && !sclk_d && link_active;
   assign sclk_fall = !sclk_s && sclk_d && link_active;

   // frame sequencer: idle, waiting for first rise, shifting
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         state <= GDS_LINK_IDLE;
      end else begin
         case (state)
            GDS_LINK_IDLE: begin
               if (cs_fall) begin
                  state <= GDS_LINK_FIRST;
               end
            end
            GDS_LINK_FIRST: begin
               if (cs_rise) begin
                  state <= GDS_LINK_IDLE;
               end else if (sclk_rise) begin
                  state <= GDS_LINK_SHIFT;
               end
            end
            GDS_LINK_SHIFT: begin
               if (cs_rise) begin
                  state <= GDS_LINK_IDLE;
               end
            end
            default: begin
               state <= GDS_LINK_IDLE;
            end
         endcase
      end
   end

   // input shift register, msb arrives first
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         rx <= '0;
      end else if (sclk_fall) begin
         rx <= {rx[`GDS_WORD_BITS-2:0], si_s};
      end
   end

   // bit count modulo 16; a nonzero flag tells empty frames from full ones
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         bit_cnt <= 4'h0;
         any_bit <= 1'b0;
      end else if (cs_fall) begin
         bit_cnt <= 4'h0;
         any_bit <= 1'b0;
      end else if (sclk_fall) begin
         bit_cnt <= bit_cnt + 4'h1;
         any_bit <= 1'b1;
      end
   end

   // the last 16 bits are ours; earlier ones belonged to chained parts
   assign frame_ok = any_bit && (bit_cnt == 4'h0);

   // output shift register: status on first rise, then the received bits
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         tx <= '0;
      end else if (sclk_rise) begin
         if (state == GDS_LINK_FIRST) begin
            tx <= status_word;
         end else begin
            tx <= {tx[`GDS_WORD_BITS-2:0], rx[0]};
         end
      end
   end

   // pin data changes only on rising serial clock
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         so_out <= 1'b0;
      end else if (sclk_rise) begin
         if (state == GDS_LINK_FIRST) begin
            so_out <= status_word[`GDS_WORD_BITS-1];
         end else begin
            so_out <= tx[`GDS_WORD_BITS-2];
         end
      end
   end

   // driver follows the synchronised select; it lags the pin by three clocks
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         so_oe <= 1'b0;
      end else begin
         so_oe <= !cs_n_s;
      end
   end

   // a whole frame is queued at select rise; if full, the frame is lost
   assign push_valid = cs_rise && frame_ok;

   gds_fifo #(
      .WIDTH(`GDS_WORD_BITS),
      .DEPTH(`GDS_FIFO_DEPTH)
   ) u_cmd_fifo (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .in_valid(push_valid),
      .in_ready(frame_ready),
      .in_data(rx),
      .out_valid(fifo_out_valid),
      .out_ready(cmd_accept),
      .out_data(fifo_out)
   );

   // the motor logic paces the writes; it can hold queued commands back
   assign pop = fifo_out_valid && cmd_accept;
   assign pop_addr = word_addr(fifo_out);

   // one register per code; codes 6 and 7 have no slot and write nothing
   generate
      for (genvar i = 0; i < `GDS_REG_COUNT; i++) begin : g_reg
         always_ff @(posedge clk_sys) begin
            if (sys_rst) begin
               reg_file[i] <= `GDS_REG_RESET;
            end else if (pop && (pop_addr == gds_addr_t'(i)) && !is_null_cmd(fifo_out)) begin
               reg_file[i] <= fifo_out[`GDS_DATA_BITS-1:0];
            end
         end

         // one-cycle notice to the motor logic that a register changed
         always_ff @(posedge clk_sys) begin
            if (sys_rst) begin
               write_strobe[i] <= 1'b0;
            end else begin
               write_strobe[i] <= pop && (pop_addr == gds_addr_t'(i))
                  && !is_null_cmd(fifo_out);
            end
         end
      end
   endgenerate

   // fixed order of the register outputs
   assign power_enable_calibration = reg_file[GDS_REG_POWER];
   assign maximum_velocity = reg_file[GDS_REG_VELOCITY];
   assign gauge0_position = reg_file[GDS_REG_GAUGE0];
   assign gauge1_position = reg_file[GDS_REG_GAUGE1];
   assign return_to_zero = reg_file[GDS_REG_RTZ];
   assign return_to_zero_config = reg_file[GDS_REG_RTZ_CFG];

   // own tally of falling clocks per frame, kept apart from bit_cnt so the checks can catch it
   logic [3:0] chk_bits;
   logic chk_seen;
   always_ff @(posedge clk_sys) begin
      if (sys_rst || cs_fall) begin
         chk_bits <= 4'h0;
         chk_seen <= 1'b0;
      end else if (!sclk_s && sclk_d && !cs_n_s) begin
         chk_bits <= chk_bits + 4'h1;
         chk_seen <= 1'b1;
      end
   end

   // checks on the link side

   drive_window_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      cs_n_s |=> !so_oe)
      else $error("serial output driven while select is high");

   idle_quiet_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (state == GDS_LINK_IDLE) && !cs_fall |=> $stable(rx) && $stable(bit_cnt))
      else $error("shift register moved outside a frame");

   input_sample_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      sclk_fall |=> (rx[0] == $past(si_s)) && (rx[15:1] == $past(rx[14:0])))
      else $error("input bit not taken on falling clock");

   output_edge_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      $changed(so_out) |-> $past(sclk_rise))
      else $error("serial output changed away from a rising clock");

   status_first_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (state == GDS_LINK_FIRST) && sclk_rise |=> (tx == $past(status_word))
         && (so_out == $past(status_word[15])))
      else $error("status word not loaded on first rising clock");

   echo_order_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (state == GDS_LINK_SHIFT) && sclk_rise |=> (tx[0] == $past(rx[0]))
         && (so_out == $past(tx[14])))
      else $error("received bit not echoed in arrival order");

   short_frame_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      cs_rise && ((chk_bits != 4'h0) || !chk_seen) |-> !push_valid)
      else $error("partial frame was queued");

   whole_frame_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      cs_rise && chk_seen && (chk_bits == 4'h0) |-> push_valid)
      else $error("whole frame was not offered to the queue");

   latch_on_rise_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      push_valid |-> cs_rise && frame_ok && (state != GDS_LINK_IDLE))
      else $error("frame queued without select rise");

   select_sync_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      $rose(cs_n) ##1 cs_n |=> cs_rise)
      else $error("select rise not seen two clocks later");

   // checks on the register side

   gauge0_write_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      pop && (fifo_out[15:13] == 3'h2) |=> write_strobe[2]
         && (gauge0_position == $past(fifo_out[12:0])))
      else $error("gauge 0 position not written from its code");

   spare_code_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      pop && (fifo_out[15:14] == 2'b11) |=> (write_strobe == '0)
         && $stable(power_enable_calibration) && $stable(gauge1_position))
      else $error("spare code changed a register");

   null_read_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      pop && (fifo_out[15:12] == 4'h1) |=> !write_strobe[0]
         && $stable(power_enable_calibration))
      else $error("null command altered the power register");

endmodule

// File: include/gds_cfg.svh
// constants of the gauge driver serial slave: field positions, codes, sizes
`ifndef GDS_CFG_SVH
`define GDS_CFG_SVH

`define GDS_WORD_BITS 16
`define GDS_DATA_BITS 13
`define GDS_ADDR_MSB 15
`define GDS_ADDR_LSB 13
`define GDS_NULL_BIT 12
`define GDS_REG_COUNT 6
`define GDS_REG_RESET 13'h0000
`define GDS_FIFO_DEPTH 8
`define GDS_ADDR_POWER 3'h0
`define GDS_ADDR_VELOCITY 3'h1
`define GDS_ADDR_GAUGE0 3'h2
`define GDS_ADDR_GAUGE1 3'h3
`define GDS_ADDR_RTZ 3'h4
`define GDS_ADDR_RTZ_CFG 3'h5
`define GDS_ADDR_UNUSED 3'h6
`define GDS_ADDR_TEST 3'h7

`endif

// File: include/gds_pkg.sv
// types of the gauge driver serial slave
`include "gds_cfg.svh"
package gds_pkg;
   typedef enum logic [2:0] {
      GDS_REG_POWER = `GDS_ADDR_POWER,
      GDS_REG_VELOCITY = `GDS_ADDR_VELOCITY,
      GDS_REG_GAUGE0 = `GDS_ADDR_GAUGE0,
      GDS_REG_GAUGE1 = `GDS_ADDR_GAUGE1,
      GDS_REG_RTZ = `GDS_ADDR_RTZ,
      GDS_REG_RTZ_CFG = `GDS_ADDR_RTZ_CFG,
      GDS_REG_UNUSED = `GDS_ADDR_UNUSED,
      GDS_REG_TEST = `GDS_ADDR_TEST
   } gds_addr_t;

   typedef enum logic [1:0] {
      GDS_LINK_IDLE = 2'b00,
      GDS_LINK_FIRST = 2'b01,
      GDS_LINK_SHIFT = 2'b10
   } gds_link_state_t;
endpackage
